/* design/gis_pkg.sv */
// Package for the bus-interface event status block: register selects, bit positions, timing.
// Assumes a 20 MHz device clock and an 8-bit host data port with a 3-bit register select.
package gis_pkg;
	localparam logic [2:0] REG_STATUS_FIRST = 3'h0;
	localparam logic [2:0] REG_STATUS_SECOND = 3'h1;
	localparam logic [2:0] REG_ADDRESSING = 3'h2;
	localparam logic [2:0] REG_MASK_FIRST = 3'h0;
	localparam logic [2:0] REG_MASK_SECOND = 3'h1;
	localparam logic [2:0] REG_AUX_CMD = 3'h3;
	// Data bit k on the host port is D(7-k): D0 is the most significant wire.
	localparam int BIT_TRIGGER = 0;
	localparam int BIT_ERROR = 1;
	localparam int BIT_UNRECOG = 2;
	localparam int BIT_PASS = 3;
	localparam int BIT_CLEAR = 4;
	localparam int BIT_OWN_ADDR = 5;
	localparam int BIT_SRQ = 6;
	localparam int BIT_IFC = 7;
	localparam int BIT_END = 4;
	localparam int BIT_POLL = 5;
	localparam int BIT_RLC = 6;
	localparam int BIT_ADDR_CHG = 7;
	localparam logic [4:0] AUX_SWRST = 5'h00;
	localparam logic [4:0] AUX_DACR = 5'h01;
	localparam logic [4:0] AUX_DAI = 5'h13;
	localparam logic [4:0] AUX_PTS = 5'h14;
	localparam logic [7:0] STATUS_RESET = 8'h00;
	localparam int CLOCK_HZ = 20000000;
	localparam int TRIGGER_PULSE_CLKS = 5;
endpackage : gis_pkg

/* design/gis_status.sv */
// Event status, mask, data-accepted holdoff and addressing state of a bus interface.
// Assumes the bus state machines present their states as synchronous levels and decoded
// command strobes qualified by the acceptor's ACDS1 condition (cmd_accept).
//
// Functional notes
// - End flag set with byte received on EOI.
// - Poll-served flag on status byte leaving, after request.
// - Remote/local change flag on any state transition.
// - Address-change flag on addressing change, not secondary.
// - Second register bits latch; clear on read, reset.
// - Unmasked command flags hold off data accepted.
// - Pass-through mask selects extended talker/listener.
// - Trigger flag and output, held through holdoff.
// - Error flag when source finds no acceptor.
// - Unrecognized command flag with addressing qualifiers.
// - Secondary unrecognized only after pass-next-secondary.
// - Secondary after own address sets pass-through flag.
// - Device clear flag on DCL or addressed SDC.
// - Service request flag while controller sees SRQ.
// - Own address flag with optional holdoff.
// - Interface clear flag unless system controller.
// - Addressing register bit order fixed.
// - Byte-out flag on any re-entry to SGNS.
// - Second register bit order fixed.
// - Flags set regardless of mask; mask gates interrupt.
// - Event during read is kept until read ends.
// - Summary bit drives interrupt unless disabled.
`timescale 1ns/1ns
module gis_status
	import gis_pkg::*;
#(
	parameter int TRIGGER_CLKS = TRIGGER_PULSE_CLKS
) (
	// Clock and reset.
	input wire logic clock,
	input wire logic rstn,
	// Host register port.
	input wire logic [2:0] reg_sel,
	input wire logic reg_rd,
	input wire logic reg_wr,
	input wire logic [7:0] wr_data,
	output logic [7:0] rd_data,
	output logic int_n,
	// Acceptor and listener events.
	input wire logic cmd_accept,
	input wire logic byte_accept,
	input wire logic eoi_in,
	input wire logic lacs,
	// Decoded commands, valid with cmd_accept.
	input wire logic cmd_get,
	input wire logic cmd_dcl,
	input wire logic cmd_sdc,
	input wire logic cmd_tct,
	input wire logic cmd_ucg_unknown,
	input wire logic cmd_acg_unknown,
	input wire logic cmd_secondary,
	input wire logic cmd_mta,
	input wire logic cmd_mla,
	input wire logic cmd_ota,
	input wire logic cmd_unl,
	input wire logic cmd_alt_primary,
	input wire logic [4:0] cmd_addr,
	// Interface function states.
	input wire logic lads,
	input wire logic tads,
	input wire logic lpas,
	input wire logic tpas,
	input wire logic remote_state_bit,
	input wire logic lockout,
	input wire logic atn_in,
	input wire logic strs,
	input wire logic service_request_bit_a,
	input wire logic service_request_bit_b,
	input wire logic sgns_out,
	input wire logic source_no_acceptor,
	input wire logic srq_in,
	input wire logic controller,
	input wire logic ifc_in,
	input wire logic system_controller,
	// Outputs to the rest of the device.
	output logic byte_received_flag,
	output logic byte_out_flag,
	output logic trigger_output,
	output logic dac_holdoff,
	output logic extended_mode,
	output logic secondary_valid,
	output logic swrst_out,
	output logic second_register_summary
);
	initial begin
		if (TRIGGER_CLKS < 1 || TRIGGER_CLKS > 255) $error("TRIGGER_CLKS out of range");
	end

	logic [7:0] mask0_q, mask1_q, stat0_q, stat1_q, ev0, ev1;
	logic swrst_q, dai_q, pts_q, csval_q, rd_q, hold_q;
	logic [7:0] pend0_q, pend1_q;
	logic [7:0] trig_cnt_q;
	logic ulpa_q;
	logic [7:0] cond_q;
	logic rem_q, llo_q, strs_q, sgns_q, addr_lst_q, addr_tlk_q, own_prev_q, tcs;

	function automatic logic [7:0] bitrev(input logic [7:0] v);
		for (int i = 0; i < 8; i++) bitrev[i] = v[7 - i];
	endfunction : bitrev

	wire rd0 = reg_rd && reg_sel == REG_STATUS_FIRST;
	wire rd1 = reg_rd && reg_sel == REG_STATUS_SECOND;
	wire aux_wr = reg_wr && reg_sel == REG_AUX_CMD;
	// The command code already sits in bits 4..0 and cs in bit 7 (D0), so no reversal here.
	wire [7:0] aux = wr_data;
	wire own_addr = cmd_accept && (cmd_mta || cmd_mla);

	// Level conditions whose rising edge sets the flag.
	logic [7:0] cond;
	always_comb begin
		cond = '0;
		cond[BIT_SRQ] = srq_in && controller;
		cond[BIT_IFC] = ifc_in && !system_controller;
		cond[BIT_ERROR] = source_no_acceptor;
	end

	always_ff @(posedge clock or negedge rstn) begin
		if (!rstn) begin
			cond_q <= '0;
			rem_q <= 1'b0;
			llo_q <= 1'b0;
			strs_q <= 1'b0;
			sgns_q <= 1'b0;
			own_prev_q <= 1'b0;
		end else begin
			cond_q <= cond;
			rem_q <= remote_state_bit;
			llo_q <= lockout;
			strs_q <= strs;
			sgns_q <= sgns_out;
			own_prev_q <= own_addr;
		end
	end

	// First-register events.
	always_comb begin
		ev0 = '0;
		ev0[BIT_END] = byte_accept && lacs && eoi_in;
		ev0[BIT_POLL] = strs_q && !strs
			&& (service_request_bit_a || service_request_bit_b);
		ev0[BIT_RLC] = (rem_q != remote_state_bit) || (llo_q != lockout);
		ev0[BIT_ADDR_CHG] = cmd_accept && !extended_mode && !cmd_alt_primary
			&& ((cmd_mta && !tads) || (cmd_ota && tads)
			|| (cmd_mla && !lads) || (cmd_unl && lads));
	end

	// Second-register events; edge detect applies to level conditions.
	always_comb begin
		ev1 = cond & ~cond_q;
		ev1[BIT_TRIGGER] = cmd_accept && cmd_get && lads;
		ev1[BIT_UNRECOG] = cmd_accept && (cmd_ucg_unknown || (cmd_acg_unknown && lads)
			|| (cmd_tct && tads) || (cmd_secondary && pts_q));
		ev1[BIT_PASS] = cmd_accept && cmd_secondary && (lpas || tpas);
		ev1[BIT_CLEAR] = cmd_accept && (cmd_dcl || (cmd_sdc && lads));
		ev1[BIT_OWN_ADDR] = own_addr && !own_prev_q;
	end

	// Register reads: status clears on the cycle after the read ends; events seen while
	// the read is active are parked so the host never loses them.
	always_ff @(posedge clock or negedge rstn) begin
		if (!rstn) begin
			rd_q <= 1'b0;
			stat0_q <= STATUS_RESET;
			stat1_q <= STATUS_RESET;
			pend0_q <= '0;
			pend1_q <= '0;
		end else if (swrst_q) begin
			rd_q <= 1'b0;
			stat0_q <= STATUS_RESET;
			stat1_q <= STATUS_RESET;
			pend0_q <= '0;
			pend1_q <= '0;
		end else begin
			rd_q <= reg_rd;
			if (rd0) begin
				pend0_q <= pend0_q | ev0;
			end else if (rd_q && reg_sel == REG_STATUS_FIRST) begin
				stat0_q <= pend0_q | ev0;
				pend0_q <= '0;
			end else begin
				stat0_q <= stat0_q | ev0;
			end
			if (rd1) begin
				pend1_q <= pend1_q | ev1;
			end else if (rd_q && reg_sel == REG_STATUS_SECOND) begin
				stat1_q <= pend1_q | ev1;
				pend1_q <= '0;
			end else begin
				stat1_q <= stat1_q | ev1;
			end
		end
	end

	// Masks: untouched by software reset, so start from zero only at power-on reset here.
	always_ff @(posedge clock or negedge rstn) begin
		if (!rstn) begin
			mask0_q <= '0;
			mask1_q <= '0;
		end else if (reg_wr && reg_sel == REG_MASK_FIRST) begin
			mask0_q <= bitrev(wr_data);
		end else if (reg_wr && reg_sel == REG_MASK_SECOND) begin
			mask1_q <= bitrev(wr_data);
		end
	end

	// Auxiliary commands handled here; swrst is set by hardware reset.
	always_ff @(posedge clock or negedge rstn) begin
		if (!rstn) begin
			swrst_q <= 1'b1;
			dai_q <= 1'b0;
			pts_q <= 1'b0;
		end else if (aux_wr) begin
			case (aux[4:0])
				AUX_SWRST: swrst_q <= aux[7];
				AUX_DAI: dai_q <= aux[7];
				AUX_PTS: pts_q <= 1'b1;
				default: ;
			endcase
		end else if (cmd_accept && cmd_secondary) begin
			pts_q <= 1'b0;
		end
	end

	// Holdoff on data accepted: set by any unmasked command flag, released by dacr.
	wire [7:0] hold_mask = 8'h3D;
	wire hold_set = |(ev1 & mask1_q & hold_mask);
	wire dacr = aux_wr && aux[4:0] == AUX_DACR;
	always_ff @(posedge clock or negedge rstn) begin
		if (!rstn) begin
			hold_q <= 1'b0;
			csval_q <= 1'b0;
		end else if (swrst_q) begin
			hold_q <= 1'b0;
			csval_q <= 1'b0;
		end else if (hold_set) begin
			hold_q <= 1'b1;
		end else if (dacr) begin
			hold_q <= 1'b0;
			csval_q <= aux[7];
		end
	end

	// Trigger output stays high through a holdoff, or a short fixed pulse when masked.
	always_ff @(posedge clock or negedge rstn) begin
		if (!rstn) begin
			trig_cnt_q <= '0;
		end else if (ev1[BIT_TRIGGER]) begin
			trig_cnt_q <= 8'(TRIGGER_CLKS);
		end else if (trig_cnt_q != 8'h00) begin
			trig_cnt_q <= trig_cnt_q - 8'h01;
		end
	end
	logic trig_hold_q;
	always_ff @(posedge clock or negedge rstn) begin
		if (!rstn) begin
			trig_hold_q <= 1'b0;
		end else if (ev1[BIT_TRIGGER] && mask1_q[BIT_TRIGGER]) begin
			trig_hold_q <= 1'b1;
		end else if (!hold_q || swrst_q) begin
			trig_hold_q <= 1'b0;
		end
	end

	// Last recognized own address LSB; the address state bits are read straight from the inputs.
	always_ff @(posedge clock or negedge rstn) begin
		if (!rstn) begin
			ulpa_q <= 1'b0;
		end else if (own_addr) begin
			ulpa_q <= cmd_addr[0];
		end
	end

	// Byte-out flag re-raised on any re-entry to SGNS, even after a pass through SIDS.
	assign tcs = sgns_out && !sgns_q;
	always_ff @(posedge clock or negedge rstn) begin
		if (!rstn) begin
			byte_out_flag <= 1'b0;
		end else if (swrst_q || (reg_wr && reg_sel == 3'h7)) begin
			byte_out_flag <= 1'b0;
		end else if (tcs) begin
			byte_out_flag <= 1'b1;
		end
	end

	always_ff @(posedge clock or negedge rstn) begin
		if (!rstn) begin
			byte_received_flag <= 1'b0;
		end else if (swrst_q || rd0) begin
			byte_received_flag <= 1'b0;
		end else if (byte_accept && lacs) begin
			byte_received_flag <= 1'b1;
		end
	end

	// Read data comes from a flop so the host sees a stable byte.
	logic int0;
	assign int0 = |(stat0_q[7:4] & mask0_q[7:4]);
	assign second_register_summary = |(stat1_q & mask1_q);
	always_ff @(posedge clock or negedge rstn) begin
		if (!rstn) begin
			rd_data <= '0;
		end else begin
			case (reg_sel)
				REG_STATUS_FIRST: rd_data <= bitrev({stat0_q[7:4], byte_out_flag,
					byte_received_flag, second_register_summary, int0});
				REG_STATUS_SECOND: rd_data <= bitrev(stat1_q);
				REG_ADDRESSING: rd_data <= bitrev({ulpa_q, tads, lads, tpas, lpas,
					atn_in, lockout, remote_state_bit});
				default: rd_data <= '0;
			endcase
		end
	end

	assign int_n = !((int0 || second_register_summary) && !dai_q);
	assign trigger_output = trig_hold_q || (trig_cnt_q != 8'h00);
	assign dac_holdoff = hold_q;
	assign extended_mode = mask1_q[BIT_PASS];
	assign secondary_valid = csval_q;
	assign swrst_out = swrst_q;
endmodule : gis_status

/* testbench/gis_host_model.sv */
// Host model: register reads, writes and holdoff release on the block's port.
// Assumes one clock; strobes change just after the rising edge.
`timescale 1ns/1ns
module gis_host_model
	import gis_pkg::*;
(
	// Clock.
	input wire logic clock,
	// Register port.
	output logic [2:0] reg_sel,
	output logic reg_rd,
	output logic reg_wr,
	output logic [7:0] wr_data,
	input wire logic [7:0] rd_data
);
	initial begin
		reg_sel = 3'h7;
		reg_rd = 1'b0;
		reg_wr = 1'b0;
		wr_data = 8'hA5;
	end
	// The released data bus shows the inverse, so a stale value never looks valid.
	task automatic wr(input logic [2:0] sel, input logic [7:0] d);
		@(posedge clock);
		reg_sel <= sel;
		wr_data <= d;
		reg_wr <= 1'b1;
		@(posedge clock);
		reg_wr <= 1'b0;
		wr_data <= ~d;
	endtask : wr
	task automatic rd(input logic [2:0] sel, output logic [7:0] d);
		@(posedge clock);
		reg_sel <= sel;
		reg_rd <= 1'b1;
		@(posedge clock);
		reg_rd <= 1'b0;
		#1 d = rd_data;
	endtask : rd
	task automatic release_holdoff(input logic cs);
		wr(REG_AUX_CMD, {cs, 2'b00, AUX_DACR});
	endtask : release_holdoff
endmodule : gis_host_model

/* testbench/gis_status_checker.sv */
// Checker for the event status block: holdoff, trigger, aux writes and reads.
// Assumes it is bound to gis_status; the host port is the only mask writer.
`timescale 1ns/1ns
module gis_status_checker
	import gis_pkg::*;
(
	// Clock and reset.
	input wire logic clock,
	input wire logic rstn,
	// Host port.
	input wire logic [2:0] reg_sel,
	input wire logic reg_rd,
	input wire logic reg_wr,
	input wire logic [7:0] wr_data,
	input wire logic [7:0] rd_data,
	// Events and outputs.
	input wire logic cmd_accept,
	input wire logic cmd_dcl,
	input wire logic remote_state_bit,
	input wire logic lads,
	input wire logic trigger_output,
	input wire logic dac_holdoff,
	input wire logic extended_mode,
	input wire logic secondary_valid,
	input wire logic swrst_out,
	input wire logic second_register_summary
);
	// The mask cannot be read back, so a shadow copy is kept here.
	logic [7:0] mask_q;
	logic aux_wr;
	assign aux_wr = reg_wr && reg_sel == REG_AUX_CMD;
	always_ff @(posedge clock or negedge rstn) begin
		if (!rstn) begin
			mask_q <= 8'h00;
		end else if (reg_wr && reg_sel == REG_MASK_SECOND) begin
			mask_q <= wr_data;
		end
	end
	default clocking @(posedge clock); endclocking
	default disable iff (!rstn);
	dcl_holdoff_a: assert property (
		cmd_accept && cmd_dcl && !swrst_out && mask_q[7 - BIT_CLEAR] |=> dac_holdoff)
		else $error("no holdoff after unmasked device clear");
	trig_pulse_a: assert property (
		$rose(trigger_output) |-> trigger_output [*4])
		else $error("trigger output too short");
	ext_mode_a: assert property (
		reg_wr && reg_sel == REG_MASK_SECOND |=> extended_mode == mask_q[7 - BIT_PASS])
		else $error("extended mode differs from mask");
	dacr_release_a: assert property (
		aux_wr && wr_data[4:0] == AUX_DACR |=> !dac_holdoff)
		else $error("holdoff not released");
	sec_valid_a: assert property (
		aux_wr && wr_data[4:0] == AUX_DACR |=> secondary_valid == $past(wr_data[7]))
		else $error("secondary valid differs from cs");
	swrst_set_a: assert property (
		aux_wr && wr_data[4:0] == AUX_SWRST |=> swrst_out == $past(wr_data[7]))
		else $error("software reset differs from cs");
	swrst_hold_a: assert property (
		swrst_out |-> !second_register_summary)
		else $error("summary set during software reset");
	addr_read_a: assert property (
		reg_rd && reg_sel == REG_ADDRESSING |=>
		rd_data[7] == $past(remote_state_bit) && rd_data[2] == $past(lads))
		else $error("addressing read bit order wrong");
endmodule : gis_status_checker

bind gis_status gis_status_checker i_gis_status_checker (.clock, .rstn, .reg_sel, .reg_rd,
	.reg_wr, .wr_data, .rd_data, .cmd_accept, .cmd_dcl, .remote_state_bit, .lads,
	.trigger_output, .dac_holdoff, .extended_mode, .secondary_valid, .swrst_out,
	.second_register_summary);

/* testbench/tb_gis_interrupt_status.sv */
// Testbench for the event status block with a host model on its register port.
// Assumes the checker is bound separately; bus events are driven here.
`timescale 1ns/1ns
module tb_gis_interrupt_status;
	import gis_pkg::*;
	logic clock, rstn, reg_rd, reg_wr, cmd_accept, byte_accept, eoi_in, lacs, int_n;
	logic [2:0] reg_sel;
	logic [7:0] wr_data, rd_data, v;
	logic [4:0] cmd_addr;
	logic cmd_get, cmd_dcl, cmd_sdc, cmd_tct, cmd_ucg_unknown, cmd_acg_unknown, cmd_secondary;
	logic cmd_mta, cmd_mla, cmd_ota, cmd_unl, cmd_alt_primary, lads, tads, lpas, tpas, strs;
	logic remote_state_bit, lockout, atn_in, service_request_bit_a, service_request_bit_b;
	logic sgns_out, source_no_acceptor, srq_in, controller, ifc_in, system_controller;
	logic byte_received_flag, byte_out_flag, trigger_output, dac_holdoff, extended_mode;
	logic secondary_valid, swrst_out, second_register_summary;
	int n_fail, comparisons;
	gis_status i_gis_status (.*);
	gis_host_model i_gis_host_model (.*);
	initial begin
		clock = 1'b0;
		forever #25 clock = ~clock;
	end
	task automatic chk(input string what, input logic [7:0] seen, input logic [7:0] exp);
		comparisons++;
		if (seen !== exp) begin
			n_fail++;
			$display("[FAIL] %s expected %h seen %h", what, exp, seen);
		end
	endtask : chk
	task automatic pulse;
		@(posedge clock);
		cmd_accept <= 1'b1;
		@(posedge clock);
		cmd_accept <= 1'b0;
		@(posedge clock);
		#1;
	endtask : pulse
	task automatic t_reset;
		#1;
		chk("swrst", {7'h00, swrst_out}, 8'h01);
		chk("int_n", {7'h00, int_n}, 8'h01);
		cmd_dcl <= 1'b1;
		pulse();
		i_gis_host_model.wr(REG_AUX_CMD, {3'b000, AUX_SWRST});
		i_gis_host_model.rd(REG_STATUS_SECOND, v);
		chk("held status", v, 8'h00);
		$display("reset test done");
	endtask : t_reset
	task automatic t_clear;
		i_gis_host_model.wr(REG_MASK_SECOND, 8'h08);
		pulse();
		chk("holdoff", {7'h00, dac_holdoff}, 8'h01);
		chk("int_n low", {7'h00, int_n}, 8'h00);
		i_gis_host_model.release_holdoff(1'b1);
		@(posedge clock);
		#1;
		chk("released", {7'h00, dac_holdoff}, 8'h00);
		chk("valid", {7'h00, secondary_valid}, 8'h01);
		i_gis_host_model.rd(REG_STATUS_SECOND, v);
		chk("clear flag", v, 8'h08);
		i_gis_host_model.rd(REG_STATUS_SECOND, v);
		chk("read clears", v, 8'h00);
		cmd_dcl <= 1'b0;
		$display("device clear test done");
	endtask : t_clear
	task automatic t_trig;
		i_gis_host_model.wr(REG_MASK_SECOND, 8'h10);
		#1;
		chk("extended", {7'h00, extended_mode}, 8'h01);
		lads <= 1'b1;
		cmd_get <= 1'b1;
		pulse();
		chk("trigger", {7'h00, trigger_output}, 8'h01);
		chk("no holdoff", {7'h00, dac_holdoff}, 8'h00);
		repeat (8) @(posedge clock);
		cmd_get <= 1'b0;
		#1;
		chk("trigger end", {7'h00, trigger_output}, 8'h00);
		i_gis_host_model.rd(REG_STATUS_SECOND, v);
		chk("masked flag", v, 8'h80);
		chk("int_n masked", {7'h00, int_n}, 8'h01);
		$display("trigger test done");
	endtask : t_trig
	task automatic t_ifc;
		system_controller <= 1'b1;
		ifc_in <= 1'b1;
		repeat (3) @(posedge clock);
		ifc_in <= 1'b0;
		system_controller <= 1'b0;
		i_gis_host_model.rd(REG_STATUS_SECOND, v);
		chk("ifc sysctl", v, 8'h00);
		ifc_in <= 1'b1;
		repeat (3) @(posedge clock);
		ifc_in <= 1'b0;
		i_gis_host_model.rd(REG_STATUS_SECOND, v);
		chk("ifc flag", v, 8'h01);
		$display("interface clear test done");
	endtask : t_ifc
	task automatic t_flags;
		lacs <= 1'b1;
		eoi_in <= 1'b1;
		@(posedge clock);
		byte_accept <= 1'b1;
		@(posedge clock);
		byte_accept <= 1'b0;
		source_no_acceptor <= 1'b1;
		@(posedge clock);
		#1;
		chk("byte in", {7'h00, byte_received_flag}, 8'h01);
		i_gis_host_model.rd(REG_STATUS_FIRST, v);
		chk("end flag", v, 8'h28);
		i_gis_host_model.rd(REG_STATUS_SECOND, v);
		chk("error flag", v, 8'h40);
		lacs <= 1'b0;
		eoi_in <= 1'b0;
		source_no_acceptor <= 1'b0;
		$display("byte and error test done");
	endtask : t_flags
	task automatic t_addr;
		remote_state_bit <= 1'b1;
		i_gis_host_model.rd(REG_ADDRESSING, v);
		chk("addressing", v, 8'h84);
		i_gis_host_model.rd(3'h4, v);
		chk("unmapped", v, 8'h00);
		$display("addressing test done");
	endtask : t_addr
	task automatic report_and_stop;
		$display("comparisons %0d mismatches %0d", comparisons, n_fail);
		if (n_fail == 0 && comparisons > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask : report_and_stop
	initial begin
		repeat (20000) @(posedge clock);
		n_fail++;
		report_and_stop();
	end
	initial begin
		rstn = 1'b0;
		cmd_addr = 5'h00;
		{cmd_accept, byte_accept, eoi_in, lacs, cmd_get, cmd_dcl, cmd_sdc, cmd_tct} = '0;
		{cmd_ucg_unknown, cmd_acg_unknown, cmd_secondary, cmd_mta, cmd_mla, cmd_ota} = '0;
		{cmd_unl, cmd_alt_primary, lads, tads, lpas, tpas, strs, remote_state_bit} = '0;
		{lockout, atn_in, service_request_bit_a, service_request_bit_b, sgns_out} = '0;
		{source_no_acceptor, srq_in, controller, ifc_in, system_controller} = '0;
		repeat (16) @(posedge clock);
		rstn <= 1'b1;
		t_reset();
		t_clear();
		t_trig();
		t_ifc();
		t_flags();
		t_addr();
		report_and_stop();
	end
endmodule : tb_gis_interrupt_status
